/* File: core/ptk_divider.v */
/*
 * Restartable frequency divider giving a one-cycle tick once per period.
 * Assumes restart comes from logic on the same clock.
 */
`timescale 1ns/1ps

module ptk_divider #(
    parameter DIV = 10
) (
    input wire ref_clk,
    input wire nrst,
    input wire restart,
    output wire tick
);
    reg [31:0] cnt_q;

    // Tick at count zero, restart reloads so the period begins anew
    assign tick = restart | (cnt_q == 32'h0000_0000);

    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            cnt_q <= 32'h0000_0000;
        end else if (tick) begin
            cnt_q <= DIV - 1;
        end else begin
            cnt_q <= cnt_q - 32'h0000_0001;
        end
    end
endmodule // ptk_divider

/* File: core/ptk_regs.vh */
/*
 * Constants of the photon timing timekeeper: clock rates, derived
 * division counts, register offsets, field positions and reset values.
 * Assumes a single reference clock at the rate given below.
 */
`ifndef PTK_REGS_VH
`define PTK_REGS_VH

// Clock and event rates
`define PTK_CLK_HZ 250000000
`define PTK_CLK_PS 16'h0FA0
`define PTK_PPS_HZ 1
`define PTK_SHOT_HZ 10000
`define PTK_IEC_HZ 25000000
`define PTK_COARSE_NS 10
`define PTK_FRAME_HZ 50

// Derived cycle counts, coarse step in ps and shots per frame
`define PTK_PPS_DIV (`PTK_CLK_HZ / `PTK_PPS_HZ)
`define PTK_SHOT_DIV (`PTK_CLK_HZ / `PTK_SHOT_HZ)
`define PTK_IEC_DIV (`PTK_CLK_HZ / `PTK_IEC_HZ)
`define PTK_COARSE_PS 16'h2710
`define PTK_SHOTS_PER_FRAME (`PTK_SHOT_HZ / `PTK_FRAME_HZ)

// Register offsets (byte addresses)
`define PTK_REG_CTRL 8'h00
`define PTK_REG_WIN_START 8'h04
`define PTK_REG_WIN_WIDTH 8'h08
`define PTK_REG_BAND_OFS 8'h0C
`define PTK_REG_CME_INT 8'h10
`define PTK_REG_CME_EXT 8'h14
`define PTK_REG_IEC_INT 8'h18
`define PTK_REG_IEC_EXT 8'h1C
`define PTK_REG_IEC_SHOT 8'h20
`define PTK_REG_FRM_STRONG 8'h24
`define PTK_REG_FRM_WEAK 8'h28
`define PTK_REG_SHOT_LAT 8'h2C
`define PTK_REG_FRM_LAT 8'h30
`define PTK_REG_IEC_NOW 8'h34

// Control fields
`define PTK_CTRL_SRC_EXT 0
`define PTK_CTRL_GPS_B 1
`define PTK_CTRL_RST 2'h0
`define PTK_WIN_RST 32'h0000_0000

`endif

/* File: core/ptk_timekeeper.v */
/*
 * Photon timing timekeeper: one-second reference generation and selection,
 * laser fire and shot clock, major frames, elapsed counters and latches,
 * shot-relative coarse time tagging, range window parameters.
 * Assumes GPS pulses and detector edges are asynchronous pins, converter
 * tags arrive on ref_clk, and software uses the plain register port.
 */
// Overview of operation
// - Internal pulse by dividing oscillator to 1 Hz
// - Internal pulse is default; GPS only fallback
// - Selected pulse goes to every counting card
// - Internal source gives exactly 10000 shots/second
// - Both pulses latch mission elapsed counter
// - Divide to 10 kHz laser fire command
// - One shot tick per laser transmit pulse
// - Frame of 200 shots at 50 Hz
// - Separate strong and weak frame counters
// - Frame counters from reset, 32 bit wrap
// - Frame interrupt at each frame boundary
// - Event logic runs in oscillator domain
// - 25 MHz elapsed counter, 40 ns steps
// - 25 MHz logic latches pulse, shot, counters
// - Elapsed counter captured on internal pulse
// - Elapsed counter stamps GPS pulse too
// - Window parameters applied at frame boundary
// - Shot clock derived from selected pulse
// - Shot tick resets coarse counter
// - Transmit flag splits start and return tags
// - Receive channels forwarded unchanged to histogrammer
// - Start detector edges timed, two thresholds
// - Coarse 10 ns count joined with fine
`timescale 1ns/1ps
`include "ptk_regs.vh"

module ptk_timekeeper #(
    parameter PPS_DIV = `PTK_PPS_DIV,
    parameter SHOT_DIV = `PTK_SHOT_DIV
) (
    input wire ref_clk,
    input wire nrst,
    input wire [7:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata,
    input wire gps_pps_a,
    input wire gps_pps_b,
    input wire [3:0] start_det_edge,
    input wire tag_valid,
    input wire tag_tx_flag,
    input wire [7:0] tag_fine,
    input wire [15:0] rx_chan,
    output wire [15:0] histogram_rx,
    output reg pps_out,
    output reg laser_fire,
    output reg shot_clock_tick,
    output reg frame_irq,
    output reg [31:0] frame_strong,
    output reg [31:0] frame_weak,
    output reg [31:0] range_window_start,
    output reg [31:0] range_window_width,
    output reg [31:0] downlink_band_offset,
    output reg start_tag_valid,
    output reg return_tag_valid,
    output reg [23:0] event_tag,
    output wire [63:0] start_det_times
);
    wire int_pps;
    wire shot_tick;
    wire iec_tick;
    wire ext_pps;
    wire sel_pps;
    wire frame_end;
    wire [3:0] start_det_rise;
    reg [5:0] sync1_q;
    reg [5:0] sync2_q;
    reg [5:0] prev_q;
    reg [1:0] ctrl_q;
    reg [31:0] win_start_stage_q;
    reg [31:0] win_width_stage_q;
    reg [31:0] band_ofs_stage_q;
    reg [31:0] cme_q;
    reg [31:0] cme_int_q;
    reg [31:0] cme_ext_q;
    reg [31:0] iec_q;
    reg [31:0] iec_int_q;
    reg [31:0] iec_ext_q;
    reg [31:0] iec_shot_q;
    reg first_armed_q;
    reg int_pend_q;
    reg ext_pend_q;
    reg shot_pend_q;
    reg [31:0] shots_since_q;
    reg [31:0] shot_lat_q;
    reg [31:0] frm_lat_q;
    reg [7:0] frame_shot_q;
    reg [15:0] coarse_q;
    reg [15:0] coarse_acc_q;
    reg coarse_tick;
    reg [15:0] acc_sum;

    // One-second internal divider, free running
    ptk_divider #(
        .DIV(PPS_DIV)
    ) u_pps_div (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .restart(1'b0),
        .tick(int_pps)
    );

    // Shot clock restarted on the distributed pulse
    ptk_divider #(
        .DIV(SHOT_DIV)
    ) u_shot_div (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .restart(sel_pps),
        .tick(shot_tick)
    );

    // 25 MHz slot enable for the elapsed-time logic
    ptk_divider #(
        .DIV(`PTK_IEC_DIV)
    ) u_iec_div (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .restart(1'b0),
        .tick(iec_tick)
    );

    // Two-stage synchroniser for asynchronous pins
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            sync1_q <= 6'h00;
            sync2_q <= 6'h00;
            prev_q <= 6'h00;
        end else begin
            sync1_q <= {start_det_edge, gps_pps_b, gps_pps_a};
            sync2_q <= sync1_q;
            prev_q <= sync2_q;
        end
    end

    // External pulse from the chosen receiver
    assign ext_pps = ctrl_q[`PTK_CTRL_GPS_B] ? (sync2_q[1] & ~prev_q[1])
                                             : (sync2_q[0] & ~prev_q[0]);
    assign sel_pps = ctrl_q[`PTK_CTRL_SRC_EXT] ? ext_pps : int_pps;
    assign start_det_rise = sync2_q[5:2] & ~prev_q[5:2];
    assign frame_end = shot_tick && (frame_shot_q == `PTK_SHOTS_PER_FRAME - 1);
    assign histogram_rx = rx_chan;

    // Coarse 10 ns step from the 4 ns clock by phase accumulation
    always @* begin
        acc_sum = coarse_acc_q + `PTK_CLK_PS;
        coarse_tick = (acc_sum >= `PTK_COARSE_PS);
    end

    // Distribution, fire command and shot tick outputs
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pps_out <= 1'b0;
            laser_fire <= 1'b0;
            shot_clock_tick <= 1'b0;
            frame_irq <= 1'b0;
        end else begin
            pps_out <= sel_pps;
            laser_fire <= shot_tick;
            shot_clock_tick <= shot_tick;
            frame_irq <= frame_end;
        end
    end

    // Mission elapsed counter and its pulse latches
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            cme_q <= 32'h0000_0000;
            cme_int_q <= 32'h0000_0000;
            cme_ext_q <= 32'h0000_0000;
        end else begin
            if (coarse_tick) begin
                cme_q <= cme_q + 32'h0000_0001;
            end
            if (int_pps) begin
                cme_int_q <= cme_q;
            end
            if (ext_pps) begin
                cme_ext_q <= cme_q;
            end
        end
    end

    // Coarse counter restarted by each shot tick
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            coarse_acc_q <= 16'h0000;
            coarse_q <= 16'h0000;
        end else begin
            if (coarse_tick) begin
                coarse_acc_q <= acc_sum - `PTK_COARSE_PS;
            end else begin
                coarse_acc_q <= acc_sum;
            end
            if (shot_tick) begin
                coarse_q <= 16'h0000;
            end else if (coarse_tick) begin
                coarse_q <= coarse_q + 16'h0001;
            end
        end
    end

    // Converter tags split by transmit flag
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            start_tag_valid <= 1'b0;
            return_tag_valid <= 1'b0;
            event_tag <= 24'h00_0000;
        end else begin
            start_tag_valid <= tag_valid & tag_tx_flag;
            return_tag_valid <= tag_valid & ~tag_tx_flag;
            if (tag_valid) begin
                event_tag <= {coarse_q, tag_fine};
            end
        end
    end

    // Start detector edge times, rising edge only on each of the four inputs
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_start_det
            reg [15:0] edge_time_q;
            always @(posedge ref_clk or negedge nrst) begin
                if (!nrst) begin
                    edge_time_q <= 16'h0000;
                end else if (start_det_rise[gi]) begin
                    edge_time_q <= coarse_q;
                end
            end
            assign start_det_times[gi*16 +: 16] = edge_time_q;
        end
    endgenerate

    // Frame position and per-beam frame counters
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            frame_shot_q <= 8'h00;
            frame_strong <= 32'h0000_0000;
            frame_weak <= 32'h0000_0000;
        end else if (shot_tick) begin
            if (frame_end) begin
                frame_shot_q <= 8'h00;
                frame_strong <= frame_strong + 32'h0000_0001;
                frame_weak <= frame_weak + 32'h0000_0001;
            end else begin
                frame_shot_q <= frame_shot_q + 8'h01;
            end
        end
    end

    // Shots since the last distributed pulse
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            shots_since_q <= 32'h0000_0000;
        end else if (sel_pps) begin
            shots_since_q <= {31'h0000_0000, shot_tick};
        end else if (shot_tick) begin
            shots_since_q <= shots_since_q + 32'h0000_0001;
        end
    end

    // Elapsed-time counter and its latches in the 25 MHz slot
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            iec_q <= 32'h0000_0000;
            iec_int_q <= 32'h0000_0000;
            iec_ext_q <= 32'h0000_0000;
            iec_shot_q <= 32'h0000_0000;
            shot_lat_q <= 32'h0000_0000;
            frm_lat_q <= 32'h0000_0000;
            int_pend_q <= 1'b0;
            ext_pend_q <= 1'b0;
            shot_pend_q <= 1'b0;
            first_armed_q <= 1'b0;
        end else begin
            if (iec_tick) begin
                iec_q <= iec_q + 32'h0000_0001;
                int_pend_q <= 1'b0;
                ext_pend_q <= 1'b0;
                shot_pend_q <= 1'b0;
            end else begin
                int_pend_q <= int_pend_q | int_pps;
                ext_pend_q <= ext_pend_q | ext_pps;
                shot_pend_q <= shot_pend_q | (shot_tick & (first_armed_q | int_pps));
            end
            if (iec_tick && (int_pend_q || int_pps)) begin
                iec_int_q <= iec_q;
                shot_lat_q <= shots_since_q;
                frm_lat_q <= frame_strong;
            end
            if (iec_tick && (ext_pend_q || ext_pps)) begin
                iec_ext_q <= iec_q;
            end
            if (iec_tick && (shot_pend_q || (shot_tick && (first_armed_q || int_pps)))) begin
                iec_shot_q <= iec_q;
            end
            if (shot_tick) begin
                first_armed_q <= 1'b0;
            end else if (int_pps) begin
                first_armed_q <= 1'b1;
            end
        end
    end

    // Register writes; window values staged then applied per frame
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_q <= `PTK_CTRL_RST;
            win_start_stage_q <= `PTK_WIN_RST;
            win_width_stage_q <= `PTK_WIN_RST;
            band_ofs_stage_q <= `PTK_WIN_RST;
            range_window_start <= `PTK_WIN_RST;
            range_window_width <= `PTK_WIN_RST;
            downlink_band_offset <= `PTK_WIN_RST;
        end else begin
            if (reg_wr) begin
                if (reg_addr == `PTK_REG_CTRL) begin
                    ctrl_q <= reg_wdata[1:0];
                end else if (reg_addr == `PTK_REG_WIN_START) begin
                    win_start_stage_q <= reg_wdata;
                end else if (reg_addr == `PTK_REG_WIN_WIDTH) begin
                    win_width_stage_q <= reg_wdata;
                end else if (reg_addr == `PTK_REG_BAND_OFS) begin
                    band_ofs_stage_q <= reg_wdata;
                end
            end
            if (frame_end) begin
                range_window_start <= win_start_stage_q;
                range_window_width <= win_width_stage_q;
                downlink_band_offset <= band_ofs_stage_q;
            end
        end
    end

    // Read data, one cycle after the strobe
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            if (reg_addr == `PTK_REG_CTRL) begin
                reg_rdata <= {30'h0000_0000, ctrl_q};
            end else if (reg_addr == `PTK_REG_WIN_START) begin
                reg_rdata <= win_start_stage_q;
            end else if (reg_addr == `PTK_REG_WIN_WIDTH) begin
                reg_rdata <= win_width_stage_q;
            end else if (reg_addr == `PTK_REG_BAND_OFS) begin
                reg_rdata <= band_ofs_stage_q;
            end else if (reg_addr == `PTK_REG_CME_INT) begin
                reg_rdata <= cme_int_q;
            end else if (reg_addr == `PTK_REG_CME_EXT) begin
                reg_rdata <= cme_ext_q;
            end else if (reg_addr == `PTK_REG_IEC_INT) begin
                reg_rdata <= iec_int_q;
            end else if (reg_addr == `PTK_REG_IEC_EXT) begin
                reg_rdata <= iec_ext_q;
            end else if (reg_addr == `PTK_REG_IEC_SHOT) begin
                reg_rdata <= iec_shot_q;
            end else if (reg_addr == `PTK_REG_FRM_STRONG) begin
                reg_rdata <= frame_strong;
            end else if (reg_addr == `PTK_REG_FRM_WEAK) begin
                reg_rdata <= frame_weak;
            end else if (reg_addr == `PTK_REG_SHOT_LAT) begin
                reg_rdata <= shot_lat_q;
            end else if (reg_addr == `PTK_REG_FRM_LAT) begin
                reg_rdata <= frm_lat_q;
            end else if (reg_addr == `PTK_REG_IEC_NOW) begin
                reg_rdata <= iec_q;
            end else begin
                reg_rdata <= 32'h0000_0000;
            end
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end
endmodule // ptk_timekeeper

/* File: tb/ptk_gps_model.sv */
/* Model of the two GPS receivers' one-second pulse pins.
   Assumes the bench calls send(); pins idle low, phase unrelated to ref_clk. */
`timescale 1ns/1ps
module ptk_gps_model #(
    parameter real WIDTH_NS = 20.0
) (
    output logic gps_pps_a,
    output logic gps_pps_b
);
    initial begin
        gps_pps_a = 1'b0;
        gps_pps_b = 1'b0;
    end

    // One active-high pulse from receiver r after a free phase offset
    task automatic send(input logic r, input real phase_ns);
        #(phase_ns);
        if (r) gps_pps_b = 1'b1;
        else gps_pps_a = 1'b1;
        #(WIDTH_NS);
        gps_pps_a = 1'b0;
        gps_pps_b = 1'b0;
    endtask
endmodule // ptk_gps_model

/* File: tb/ptk_props.sv */
/* Checker of the timekeeper pulse, frame, tag and pass-through behaviour.
   Assumes a bind to ptk_timekeeper with the internal source selected at reset. */
`timescale 1ns/1ps
module ptk_props #(
    parameter PPS_DIV = 1000,
    parameter SHOT_DIV = 100
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic tag_valid,
    input wire logic tag_tx_flag,
    input wire logic [7:0] tag_fine,
    input wire logic [15:0] rx_chan,
    input wire logic [15:0] histogram_rx,
    input wire logic pps_out,
    input wire logic laser_fire,
    input wire logic shot_clock_tick,
    input wire logic frame_irq,
    input wire logic [31:0] frame_strong,
    input wire logic [31:0] frame_weak,
    input wire logic start_tag_valid,
    input wire logic return_tag_valid,
    input wire logic [23:0] event_tag
);
    localparam int SHOTS = PPS_DIV / SHOT_DIV;
    localparam int FRM = 200 * SHOT_DIV - 1;
    logic [31:0] cc_q, fc_q, sc_q;
    logic ext_q, shot_q, irq_q, pps_q;
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!nrst);

    // Cycle and shot counts since the last pulses; ext_q once external is chosen
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            cc_q <= 32'h0;
            fc_q <= 32'h0;
            sc_q <= 32'h0;
            ext_q <= 1'b0;
            shot_q <= 1'b0;
            irq_q <= 1'b0;
            pps_q <= 1'b0;
        end else begin
            cc_q <= shot_clock_tick ? 32'h0 : cc_q + 32'h1;
            fc_q <= frame_irq ? 32'h0 : fc_q + 32'h1;
            sc_q <= pps_out ? 32'h1 : sc_q + {31'h0, shot_clock_tick};
            ext_q <= ext_q | (reg_wr & (reg_addr == 8'h00) & reg_wdata[0]);
            shot_q <= shot_q | shot_clock_tick;
            irq_q <= irq_q | frame_irq;
            pps_q <= pps_q | pps_out;
        end
    end

    fire_with_tick_a: assert property (laser_fire == shot_clock_tick)
        else $error("laser fire and shot tick differ");
    tick_single_a: assert property (shot_clock_tick |=> !shot_clock_tick [*8])
        else $error("shot tick longer than one cycle");
    shot_period_a: assert property (shot_clock_tick && shot_q && !ext_q |-> cc_q == SHOT_DIV - 1)
        else $error("shot tick spacing wrong");
    pps_shot_a: assert property (pps_out |-> shot_clock_tick)
        else $error("pulse without shot tick");
    shots_per_sec_a: assert property (pps_out && pps_q && !ext_q |-> sc_q == SHOTS)
        else $error("shot count per second wrong");
    frame_period_a: assert property (frame_irq && irq_q && !ext_q |-> fc_q == FRM)
        else $error("frame interrupt spacing wrong");
    frame_step_a: assert property (frame_strong != $past(frame_strong) |->
        frame_strong == $past(frame_strong) + 32'h1 && frame_weak == $past(frame_weak) + 32'h1)
        else $error("frame counters step wrong");
    tag_kind_a: assert property (tag_valid |=> start_tag_valid == $past(tag_tx_flag) &&
        return_tag_valid != $past(tag_tx_flag) && event_tag[7:0] == $past(tag_fine))
        else $error("tag kind or fine value wrong");
    tag_quiet_a: assert property (!$past(tag_valid) |-> !start_tag_valid && !return_tag_valid)
        else $error("tag valid without tag");
    hist_pass_a: assert property (histogram_rx == rx_chan)
        else $error("receive channels not passed through");

    cover property (frame_irq && irq_q);
    cover property (tag_valid && tag_tx_flag);
    cover property (pps_out && ext_q);
endmodule // ptk_props

bind ptk_timekeeper ptk_props #(
    .PPS_DIV(PPS_DIV),
    .SHOT_DIV(SHOT_DIV)
) u_props (
    .ref_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .tag_valid, .tag_tx_flag, .tag_fine,
    .rx_chan, .histogram_rx, .pps_out, .laser_fire, .shot_clock_tick, .frame_irq,
    .frame_strong, .frame_weak, .start_tag_valid, .return_tag_valid, .event_tag
);

/* File: tb/tb.sv */
/* Self-checking bench of the photon timing timekeeper.
   Assumes shortened dividers: one second is PPS cycles, one shot SHOT cycles. */
`timescale 1ns/1ps
module tb;
    localparam int PPS = 1000;
    localparam int SHOT = 100;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic tag_valid = 1'b0;
    logic tag_tx_flag = 1'b0;
    logic [7:0] tag_fine = 8'h00;
    logic [15:0] rx_chan = 16'h0000;
    logic [3:0] start_det_edge = 4'h0;
    wire [63:0] start_det_times;
    wire [31:0] reg_rdata, frame_strong, frame_weak;
    wire [31:0] range_window_start, range_window_width, downlink_band_offset;
    wire [15:0] histogram_rx;
    wire [23:0] event_tag;
    wire gps_pps_a, gps_pps_b, pps_out, laser_fire, shot_clock_tick, frame_irq;
    wire start_tag_valid, return_tag_valid;
    int err_count = 0;
    int checked = 0;

    always #2 ref_clk = ~ref_clk;

    ptk_gps_model gps (.gps_pps_a, .gps_pps_b);

    ptk_timekeeper #(.PPS_DIV(PPS), .SHOT_DIV(SHOT)) dut (
        .ref_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .gps_pps_a, .gps_pps_b, .start_det_edge, .tag_valid, .tag_tx_flag, .tag_fine,
        .rx_chan, .histogram_rx, .pps_out, .laser_fire, .shot_clock_tick, .frame_irq,
        .frame_strong, .frame_weak, .range_window_start, .range_window_width,
        .downlink_band_offset, .start_tag_valid, .return_tag_valid, .event_tag,
        .start_det_times
    );

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_b(input string what, input logic exp, input logic got);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    // Waits for pps_out (0), frame_irq (1) or shot tick (2); n = cycles before the hit, lim if none
    task automatic wait_sig(input int sel, input int lim, output int n);
        for (n = 0; n < lim; n++) begin
            @(posedge ref_clk);
            #1;
            if ((sel == 0 && pps_out === 1'b1) || (sel == 1 && frame_irq === 1'b1) ||
                (sel == 2 && shot_clock_tick === 1'b1)) break;
        end
    endtask

    task automatic t_regs();
        logic [31:0] d;
        rd(8'h00, d);
        chk("ctrl_reset", 32'h0, d);
        wr(8'h00, 32'h0000_0002);
        rd(8'h00, d);
        chk("ctrl_gps_b", 32'h2, d);
        wr(8'h00, 32'h0);
        wr(8'h24, 32'hFFFF_FFFF);
        rd(8'h24, d);
        chk("frame_ro", 32'h0, d);
        rd(8'h3C, d);
        chk("unmapped", 32'h0, d);
    endtask

    task automatic t_tag();
        int n;
        wait_sig(2, 2 * SHOT, n);
        @(posedge ref_clk);
        tag_valid <= 1'b1;
        tag_tx_flag <= 1'b1;
        tag_fine <= 8'h5A;
        rx_chan <= 16'hA5C3;
        start_det_edge <= 4'h1;
        @(posedge ref_clk);
        tag_tx_flag <= 1'b0;
        tag_fine <= 8'hC3;
        #1;
        chk_b("start_valid", 1'b1, start_tag_valid);
        chk_b("return_quiet", 1'b0, return_tag_valid);
        chk("fine", 32'h5A, {24'h0, event_tag[7:0]});
        chk_b("coarse_reset", 1'b1, event_tag[23:8] <= 16'h0002);
        chk("hist", 32'hA5C3, {16'h0, histogram_rx});
        @(posedge ref_clk);
        tag_valid <= 1'b0;
        #1;
        chk_b("return_valid", 1'b1, return_tag_valid);
        chk("fine_2", 32'hC3, {24'h0, event_tag[7:0]});
        @(posedge ref_clk);
        #1;
        chk_b("lead_time", 1'b1, start_det_times[15:0] >= 16'h0001 &&
            start_det_times[15:0] <= 16'h0002);
        chk("other_edges_quiet", 32'h0, start_det_times[47:16]);
    endtask

    task automatic t_pps();
        int n, s, f, i;
        logic [31:0] a[4], b[4];
        logic [7:0] ad[4] = '{8'h10, 8'h18, 8'h20, 8'h2C};
        wait_sig(0, PPS + 8, n);
        s = 0;
        f = 0;
        for (n = 1; n < PPS + 8; n++) begin
            @(posedge ref_clk);
            #1;
            if (pps_out === 1'b1) break;
            s += shot_clock_tick;
            f += laser_fire;
        end
        chk("pps_period", PPS, n);
        chk("shots", PPS / SHOT - 1, s);
        chk("fires", PPS / SHOT - 1, f);
        repeat (12) @(posedge ref_clk);
        for (i = 0; i < 4; i++) rd(ad[i], a[i]);
        wait_sig(0, PPS, n);
        repeat (12) @(posedge ref_clk);
        for (i = 0; i < 4; i++) rd(ad[i], b[i]);
        chk("mission_step", PPS * 4 / 10, b[0] - a[0]);
        chk("elapsed_step", PPS / 10, b[1] - a[1]);
        chk("first_shot_step", PPS / 10, b[2] - a[2]);
        chk("shot_count_lat", PPS / SHOT, b[3]);
    endtask

    task automatic t_frame();
        int n;
        logic [31:0] d;
        wr(8'h04, 32'h0000_1234);
        wr(8'h08, 32'h0000_0456);
        wr(8'h0C, 32'h0000_0078);
        rd(8'h04, d);
        chk("win_start_staged", 32'h1234, d);
        chk("win_start_held", 32'h0, range_window_start);
        chk("strong_0", 32'h0, frame_strong);
        wait_sig(1, 200 * SHOT, n);
        repeat (3) @(posedge ref_clk);
        #1;
        chk("win_start", 32'h1234, range_window_start);
        chk("win_width", 32'h456, range_window_width);
        chk("band_offset", 32'h78, downlink_band_offset);
        chk("strong_1", 32'h1, frame_strong);
        chk("weak_1", 32'h1, frame_weak);
        wait_sig(1, 200 * SHOT, n);
        chk("frame_gap", 200 * SHOT - 4, n);
    endtask

    task automatic t_ext();
        int n;
        logic [31:0] a, b;
        rd(8'h1C, a);
        gps.send(1'b0, 1.3);
        repeat (12) @(posedge ref_clk);
        rd(8'h1C, b);
        chk_b("ext_stamp", 1'b1, b != a);
        rd(8'h14, a);
        chk_b("mission_ext", 1'b1, a != 32'h0);
        wr(8'h00, 32'h0000_0001);
        fork
            gps.send(1'b1, 2.7);
        join_none
        wait_sig(0, PPS + 8, n);
        chk("gps_b_ignored", PPS + 8, n);
        fork
            gps.send(1'b0, 0.6);
        join_none
        wait_sig(0, 12, n);
        chk_b("ext_pps", 1'b1, pps_out);
        chk_b("ext_shot", 1'b1, shot_clock_tick);
        wr(8'h00, 32'h0);
        wait_sig(0, PPS + 8, n);
        chk_b("int_back", 1'b1, pps_out);
    endtask

    task automatic end_of_test();
        $display("checked %0d err_count %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        repeat (8) @(posedge ref_clk);
        nrst <= 1'b1;
        t_regs();
        t_tag();
        t_pps();
        t_frame();
        t_ext();
        end_of_test();
    end

    initial begin
        #300_000;
        err_count++;
        end_of_test();
    end
endmodule // tb
